// ==== vpos_pkg.sv ====
// Constants and types for the valve positioner auxiliary functions.
// Assumes percentages in 0.1 % steps and loop current in 0.01 mA steps.
package vpos_pkg;
  // Timing
  localparam int CLK_HZ = 125_000_000;
  localparam int PERIOD_US = 1000;
  localparam int PERIOD_CYC = CLK_HZ / 1_000_000 * PERIOD_US;
  // Stroke scale, 0.1 % units
  localparam logic [9:0] FULL = 10'h3E8;
  localparam logic [9:0] HALF = 10'h1F4;
  localparam logic [9:0] LO_RESET = 10'h000;
  localparam logic [9:0] HI_RESET = 10'h3E8;
  // Travel times, seconds; deadband, gain and safety resets follow
  localparam logic [5:0] T_MIN = 6'h01;
  localparam logic [5:0] T_MAX = 6'h3C;
  localparam logic [5:0] T_RESET = 6'h3C;
  localparam logic [9:0] DB_RESET = 10'h00A;
  localparam logic [7:0] KP_RESET = 8'h10;
  localparam logic [9:0] SAFE_RESET = 10'h000;
  // Loop current, 0.01 mA units
  localparam logic [11:0] MA_FAULT = 12'h15E;
  localparam logic [11:0] MA_HYST = 12'h00A;
  localparam logic [11:0] MA_LIVE_ZERO = 12'h190;
  // Register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_LIMIT = 8'h04;
  localparam logic [7:0] OFS_TIME = 8'h08;
  localparam logic [7:0] OFS_LOOP = 8'h0C;
  localparam logic [7:0] OFS_SAFE = 8'h10;
  localparam logic [7:0] OFS_STATUS = 8'h14;
  // CTRL fields
  localparam int CTRL_BIN = 0;
  localparam int CTRL_SAFE_EN = 2;
  localparam int CTRL_ERR_EN = 3;
  localparam int CTRL_IN_0_20 = 4;
  localparam int CTRL_OUT_SP = 5;
  localparam int CTRL_OUT_0_20 = 6;
  localparam int CTRL_TUNE_GO = 7;
  // Other fields
  localparam int LIM_HI = 16;
  localparam int TIME_CLOSE = 8;
  localparam int LOOP_KP_OPEN = 16;
  localparam int LOOP_KP_CLOSE = 24;
  localparam int ST_FAULT = 12;
  localparam int ST_MANUAL = 13;
  localparam int ST_TUNING = 14;
  localparam int ST_SAFE = 15;

  typedef enum logic [1:0] {
    BIN_NONE = 2'h0,
    BIN_SAFE = 2'h1,
    BIN_MODE = 2'h2,
    BIN_TUNE = 2'h3
  } bin_func_t;

  typedef enum logic [1:0] {
    TS_IDLE = 2'b01,
    TS_RUN = 2'b10
  } tune_state_t;

  typedef struct packed {
    logic [5:0] open_s;
    logic [5:0] close_s;
    logic [9:0] deadband;
  } tune_res_t;
endpackage

// ==== vpos_aux.sv ====
// Position loop auxiliary functions of a valve positioner with APB registers.
// Assumes synchronous inputs and an external tuning engine.
// Notes on behaviour
// - Limited span rescales to 100 %; outside positions read below 0 or above 100.
// - Lower limit resets to 0 %, upper limit to 100 %.
// - Lower limit clamps into 0-50 %, upper into 50-100 %.
// - Limits stay at least 50 % apart; writing one pushes the other.
// - Separate open and close full-stroke times, 1 to 60 seconds.
// - Tuning stores measured minimum open and close times.
// - Error inside deadband, a share of the limited span, gives no drive.
// - Tuning loads the measured deadband; software may still rewrite it.
// - Independent gains for opening and closing directions.
// - Safety position only on binary request or input fault, in automatic.
// - Safety target clamped inside the stroke limits when safety position is enabled; the 0 % end is not.
// - In 4-20 mA range, fault at or below 3.5 mA with 0.5 % hysteresis.
// - In 0-20 mA range break detection cannot be enabled.
// - Red set-point error indicator lit while input fault is present.
// - On fault go to safety position if enabled, else de-energised end.
// - Binary input function: safety position, mode switch or tuning start.
// - Binary safety request uses safety position if enabled, else end position.
// - Mode function: input 0 automatic, 1 manual; selector switch ignored.
// - Tuning function: a rising edge of the input starts tuning.
// - Analog output shows position or set-point, 4-20 or 0-20 mA.
// - Tuning starts only in automatic mode.
`timescale 1ns/100ps
`default_nettype none
module vpos_aux import vpos_pkg::*; #(
  parameter int TICK_CYCLES = PERIOD_CYC
) (
  // Clock and reset
  input wire logic REF_CLK,
  input wire logic RST_N,
  // APB slave
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // Process side
  input wire logic [11:0] SETPOINT_MA,
  input wire logic [9:0] POSITION,
  input wire logic BIN_IN,
  input wire logic MODE_SW,
  // Tuning engine
  input wire logic TUNE_DONE,
  input wire tune_res_t TUNE_RES,
  output logic TUNE_ACTIVE,
  // Actuator and feedback
  output logic signed [15:0] DRIVE,
  output logic SP_ERR_LED,
  output logic [11:0] ANALOG_OUT
);

  function automatic logic [9:0] clamp10(input logic [9:0] v, input logic [9:0] lo,
                                         input logic [9:0] hi);
    clamp10 = (v < lo) ? lo : ((v > hi) ? hi : v);
  endfunction

  function automatic logic [5:0] clamp_t(input logic [5:0] v);
    clamp_t = (v < T_MIN) ? T_MIN : ((v > T_MAX) ? T_MAX : v);
  endfunction

  function automatic logic [25:0] step_of(input logic [5:0] t);
    step_of = 26'((64'(FULL) * 64'd65536 * 64'(PERIOD_US)) / (64'(t) * 64'd1000000));
  endfunction

  logic [1:0] bin_func;
  logic safe_en, err_en, in_0_20, out_sp, out_0_20;
  logic [9:0] lim_lo, lim_hi, deadband, safe_pos;
  logic [5:0] t_open, t_close;
  logic [7:0] kp_open, kp_close;
  logic fault, bin_q;
  logic [25:0] ramp;
  logic [16:0] tick_cnt;
  tune_state_t tstate;

  // Bus decode
  wire access = PSEL && PENABLE;
  wire wr = access && PWRITE;
  wire hit_ctrl = PADDR == OFS_CTRL;
  wire hit_limit = PADDR == OFS_LIMIT;
  wire hit_time = PADDR == OFS_TIME;
  wire hit_loop = PADDR == OFS_LOOP;
  wire hit_safe = PADDR == OFS_SAFE;
  wire hit_status = PADDR == OFS_STATUS;
  wire mapped = hit_ctrl || hit_limit || hit_time || hit_loop || hit_safe || hit_status;
  assign PREADY = 1'b1;
  assign PSLVERR = access && (!mapped || (PWRITE && hit_status));

  // Limit write with clamping and minimum gap
  wire [9:0] w_lo = clamp10(PWDATA[9:0], 10'h000, HALF);
  wire [9:0] w_hi = clamp10(PWDATA[LIM_HI+:10], HALF, FULL);
  wire lo_moved = w_lo != lim_lo;
  wire [9:0] next_lo = lo_moved ? w_lo : ((w_hi - lim_lo < HALF) ? w_hi - HALF : lim_lo);
  wire [9:0] next_hi = (next_lo + HALF > w_hi) ? next_lo + HALF : w_hi;

  // Operating mode
  wire manual = (bin_func == BIN_MODE) ? BIN_IN : MODE_SW;
  wire automatic_mode = !manual;
  wire bin_rise = BIN_IN && !bin_q;
  wire tune_go = automatic_mode && tstate == TS_IDLE &&
                 ((bin_func == BIN_TUNE && bin_rise) ||
                  (wr && hit_ctrl && PWDATA[CTRL_TUNE_GO]));
  wire tune_run = tstate == TS_RUN;
  wire track = manual || tune_run;
  wire tune_end = tune_run && (TUNE_DONE || manual);
  wire tune_store = tune_run && TUNE_DONE;
  wire next_tune_active = (tune_run && !tune_end) || tune_go;

  // Input conversion and fault detection
  wire [11:0] fault_clr = MA_FAULT + MA_HYST;
  wire fault_on = SETPOINT_MA <= MA_FAULT;
  wire fault_off = SETPOINT_MA > fault_clr;
  wire fault_act = fault && err_en && !in_0_20;
  wire [11:0] live = (SETPOINT_MA > MA_LIVE_ZERO) ? SETPOINT_MA - MA_LIVE_ZERO : 12'h000;
  wire [13:0] sp_raw = in_0_20 ? 14'(SETPOINT_MA >> 1) : 14'((16'(live) * 16'd5) >> 3);
  wire [9:0] sp_pct = (sp_raw > 14'(FULL)) ? FULL : sp_raw[9:0];

  // Scaling to and from the limited span
  wire [9:0] span = lim_hi - lim_lo;
  wire signed [31:0] pos_rel = $signed(32'(POSITION)) - $signed(32'(lim_lo));
  wire signed [31:0] pos_scaled = (pos_rel * $signed(32'(FULL))) / $signed(32'(span));
  wire [19:0] sp_span = 20'(sp_pct) * 20'(span);
  wire [9:0] tgt_auto = lim_lo + 10'(sp_span / 20'(FULL));

  // Safety position selection
  wire bin_safe = bin_func == BIN_SAFE && BIN_IN;
  wire safe_act = automatic_mode && (bin_safe || fault_act);
  wire [9:0] safe_clamped = clamp10(safe_pos, lim_lo, lim_hi);
  wire [9:0] safe_tgt = safe_en ? safe_clamped : 10'h000;
  wire [9:0] target = safe_act ? safe_tgt : tgt_auto;

  // Set-point ramp
  wire tick = tick_cnt == 17'(TICK_CYCLES - 1);
  wire [25:0] tgt_fx = {target, 16'h0000};
  wire [25:0] up = ramp + step_of(t_open);
  wire [25:0] dn = ramp - step_of(t_close);
  wire rising = ramp < tgt_fx;
  wire up_past = up > tgt_fx || up < ramp;
  wire dn_past = ramp - tgt_fx < step_of(t_close);
  wire [25:0] next_ramp = rising ? (up_past ? tgt_fx : up) : (dn_past ? tgt_fx : dn);

  // Loop error, deadband and gains
  wire signed [31:0] err = $signed(32'(ramp[25:16])) - $signed(32'(POSITION));
  wire [31:0] err_abs = err[31] ? 32'(-err) : 32'(err);
  wire [19:0] db_span = 20'(deadband) * 20'(span);
  wire [31:0] db_full = 32'(db_span / 20'(FULL));
  wire [7:0] kp = err[31] ? kp_close : kp_open;
  wire signed [31:0] drv_raw = (err * $signed(32'(kp))) >>> 4;
  wire signed [15:0] drv_sat = (drv_raw > 32'sd32767) ? 16'sh7FFF :
                               (drv_raw < -32'sd32768) ? -16'sh8000 : 16'(drv_raw);
  wire signed [15:0] next_drive = (manual || tstate == TS_RUN || err_abs <= db_full) ?
                                  16'sh0000 : drv_sat;

  // Analog feedback
  wire [9:0] pos_clip = pos_scaled[31] ? 10'h000 :
                        (pos_scaled > $signed(32'(FULL))) ? FULL : pos_scaled[9:0];
  wire [9:0] fb = out_sp ? sp_pct : pos_clip;
  wire [11:0] next_aout = out_0_20 ? 12'({2'b00, fb} << 1) :
                          MA_LIVE_ZERO + 12'((16'(fb) * 16'd8) / 16'd5);

  // Status word
  wire [31:0] status = {16'h0000, safe_act, tstate == TS_RUN, manual, fault_act,
                        pos_scaled[11:0]};
  wire [31:0] rd_ctrl = {25'h0, out_0_20, out_sp, in_0_20, err_en, safe_en, bin_func};
  logic [31:0] rd_mux;
  always_comb begin
    if (hit_ctrl) begin
      rd_mux = rd_ctrl;
    end else if (hit_limit) begin
      rd_mux = {6'h0, lim_hi, 6'h0, lim_lo};
    end else if (hit_time) begin
      rd_mux = {18'h0, t_close, 2'h0, t_open};
    end else if (hit_loop) begin
      rd_mux = {kp_close, kp_open, 6'h0, deadband};
    end else if (hit_safe) begin
      rd_mux = {22'h0, safe_pos};
    end else if (hit_status) begin
      rd_mux = status;
    end else begin
      rd_mux = 32'h0000_0000;
    end
  end

  // Configuration registers
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      bin_func <= BIN_NONE;
      safe_en <= 1'b0;
      err_en <= 1'b0;
      in_0_20 <= 1'b0;
      out_sp <= 1'b0;
      out_0_20 <= 1'b0;
    end else if (wr && hit_ctrl) begin
      bin_func <= PWDATA[CTRL_BIN+:2];
      safe_en <= PWDATA[CTRL_SAFE_EN];
      in_0_20 <= PWDATA[CTRL_IN_0_20];
      err_en <= PWDATA[CTRL_ERR_EN] && !PWDATA[CTRL_IN_0_20];
      out_sp <= PWDATA[CTRL_OUT_SP];
      out_0_20 <= PWDATA[CTRL_OUT_0_20];
    end
  end

  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      lim_lo <= LO_RESET;
      lim_hi <= HI_RESET;
    end else if (wr && hit_limit) begin
      lim_lo <= next_lo;
      lim_hi <= next_hi;
    end
  end

  // Safety position, kept within full stroke
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      safe_pos <= SAFE_RESET;
    end else if (wr && hit_safe) begin
      safe_pos <= clamp10(PWDATA[9:0], 10'h000, FULL);
    end
  end

  // Travel times; tuning results take over on completion
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      t_open <= T_RESET;
      t_close <= T_RESET;
    end else if (tune_store) begin
      t_open <= clamp_t(TUNE_RES.open_s);
      t_close <= clamp_t(TUNE_RES.close_s);
    end else if (wr && hit_time) begin
      t_open <= clamp_t(PWDATA[5:0]);
      t_close <= clamp_t(PWDATA[TIME_CLOSE+:6]);
    end
  end

  // Deadband from tuning, still writable afterwards
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      deadband <= DB_RESET;
    end else if (tune_store) begin
      deadband <= TUNE_RES.deadband;
    end else if (wr && hit_loop) begin
      deadband <= PWDATA[9:0];
    end
  end

  // Gains; a loop write is dropped in a cycle that stores a tuning result
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      kp_open <= KP_RESET;
      kp_close <= KP_RESET;
    end else if (wr && hit_loop && !tune_store) begin
      kp_open <= PWDATA[LOOP_KP_OPEN+:8];
      kp_close <= PWDATA[LOOP_KP_CLOSE+:8];
    end
  end

  // Tuning sequence
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      tstate <= TS_IDLE;
    end else begin
      case (tstate)
        TS_IDLE: begin
          if (tune_go) begin
            tstate <= TS_RUN;
          end
        end
        TS_RUN: begin
          if (TUNE_DONE || manual) begin
            tstate <= TS_IDLE;
          end
        end
        default: begin
          tstate <= TS_IDLE;
        end
      endcase
    end
  end

  // Fault latch with hysteresis
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      fault <= 1'b0;
    end else if (fault_on) begin
      fault <= 1'b1;
    end else if (fault_off) begin
      fault <= 1'b0;
    end
  end

  // Control period counter
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      tick_cnt <= 17'h00000;
    end else begin
      tick_cnt <= tick ? 17'h00000 : tick_cnt + 17'h00001;
    end
  end

  // Previous binary input, idle low, for the tuning start edge
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      bin_q <= 1'b0;
    end else begin
      bin_q <= BIN_IN;
    end
  end

  // Ramp follows the valve when not under automatic control
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      ramp <= 26'h0000000;
    end else if (track) begin
      ramp <= {POSITION, 16'h0000};
    end else if (tick) begin
      ramp <= next_ramp;
    end
  end

  // Drive command
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      DRIVE <= 16'sh0000;
    end else begin
      DRIVE <= next_drive;
    end
  end

  // Set-point error indicator
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      SP_ERR_LED <= 1'b0;
    end else begin
      SP_ERR_LED <= fault_act;
    end
  end

  // Analog feedback current
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      ANALOG_OUT <= 12'h000;
    end else begin
      ANALOG_OUT <= next_aout;
    end
  end

  // Tuning flag tracks the state register, so it drops with the done pulse
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      TUNE_ACTIVE <= 1'b0;
    end else begin
      TUNE_ACTIVE <= next_tune_active;
    end
  end

  // Read data captured in the setup cycle, held until the next read
  wire rd_setup = PSEL && !PENABLE && !PWRITE;
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      PRDATA <= 32'h0000_0000;
    end else begin
      if (rd_setup) begin
        PRDATA <= rd_mux;
      end
    end
  end

endmodule
`default_nettype wire

// ==== vpos_aux_sva.sv ====
// Port checker for the valve positioner auxiliary block.
// Assumes it is bound to vpos_aux and clocked by REF_CLK.
`timescale 1ns/100ps
`default_nettype none
module vpos_aux_sva import vpos_pkg::*; (
  // Clock and reset
  input wire logic REF_CLK,
  input wire logic RST_N,
  // APB
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic [31:0] PRDATA,
  input wire logic PREADY,
  input wire logic PSLVERR,
  // Process and tuning
  input wire logic [11:0] SETPOINT_MA,
  input wire logic BIN_IN,
  input wire logic TUNE_DONE,
  input wire logic TUNE_ACTIVE,
  input wire logic signed [15:0] DRIVE,
  input wire logic SP_ERR_LED
);
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!RST_N);
  wire acc = PSEL && PENABLE;
  wire bad = PADDR > OFS_STATUS || PADDR[1:0] != 2'h0;
  wire ro = PWRITE && PADDR == OFS_STATUS;
  wire go = acc && PWRITE && PADDR == OFS_CTRL && PWDATA[CTRL_TUNE_GO];
  chk_ready_high: assert property (PREADY) else $error("pready low");
  chk_err_unmapped: assert property (acc && bad |-> PSLVERR) else $error("no error");
  chk_err_status: assert property (acc && ro |-> PSLVERR) else $error("status write taken");
  chk_err_quiet: assert property (!acc || (!bad && !ro) |-> !PSLVERR) else $error("stray error");
  chk_unmapped_zero: assert property (acc && !PWRITE && bad |-> PRDATA == 32'h0)
    else $error("unmapped data");
  chk_rdata_hold: assert property (!(PSEL && !PENABLE && !PWRITE) |=> $stable(PRDATA))
    else $error("read data moved");
  chk_led_clear: assert property ((SETPOINT_MA > 12'h168) [*3] |-> !SP_ERR_LED)
    else $error("led stuck");
  chk_tune_nodrive: assert property (TUNE_ACTIVE [*2] |-> DRIVE == 16'h0000)
    else $error("drive while tuning");
  chk_done_ends: assert property (TUNE_ACTIVE && TUNE_DONE |=> !TUNE_ACTIVE)
    else $error("tuning not ended");
  chk_tune_cause: assert property ($rose(TUNE_ACTIVE) |-> $past(go) || $past(BIN_IN))
    else $error("tuning without request");
endmodule
bind vpos_aux vpos_aux_sva u_sva (.REF_CLK(REF_CLK), .RST_N(RST_N), .PSEL(PSEL),
  .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
  .PREADY(PREADY), .PSLVERR(PSLVERR), .SETPOINT_MA(SETPOINT_MA), .BIN_IN(BIN_IN),
  .TUNE_DONE(TUNE_DONE), .TUNE_ACTIVE(TUNE_ACTIVE), .DRIVE(DRIVE), .SP_ERR_LED(SP_ERR_LED));
`default_nettype wire

// ==== vpos_far.sv ====
// Actuator and tuning engine beside the positioner block.
// Assumes the bench sets the rest position while drive is zero.
`timescale 1ns/100ps
`default_nettype none
module vpos_far import vpos_pkg::*; #(
  parameter tune_res_t RES = tune_res_t'{6'h05, 6'h07, 10'h014}
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Bench control
  input wire logic [9:0] hold_pos,
  // Design side
  input wire logic signed [15:0] drive,
  input wire logic tune_active,
  output logic [9:0] position,
  output logic tune_done,
  output tune_res_t tune_res
);
  logic [5:0] cnt;
  // Results only valid with the done pulse
  assign tune_res = tune_done ? RES : ~RES;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      position <= 10'h000;
      cnt <= 6'h00;
      tune_done <= 1'b0;
    end else begin
      if (drive > 0 && position < FULL) position <= position + 10'h001;
      else if (drive < 0 && position != 10'h000) position <= position - 10'h001;
      else if (drive == 0) position <= hold_pos;
      cnt <= !tune_active ? 6'h00 : (cnt == 6'h3F ? cnt : cnt + 6'h01);
      tune_done <= tune_active && cnt == 6'h13;
    end
  end
endmodule
`default_nettype wire

// ==== vpos_aux_bench.sv ====
// Self-checking bench for the valve positioner auxiliary block.
// Assumes the bound checker and the far-side model.
`timescale 1ns/100ps
`default_nettype none
module vpos_aux_bench import vpos_pkg::*;;
  logic REF_CLK = 0, RST_N = 0, PSEL = 0, PENABLE = 0, PWRITE = 0, BIN_IN = 0, MODE_SW = 0;
  logic [7:0] PADDR = 0;
  logic [31:0] PWDATA = 0, PRDATA, r;
  logic PREADY, PSLVERR, TUNE_DONE, TUNE_ACTIVE, SP_ERR_LED, e;
  logic [11:0] SETPOINT_MA = 12'h4B0, ANALOG_OUT;
  logic [9:0] POSITION, hold = 0;
  logic signed [15:0] DRIVE;
  tune_res_t TUNE_RES;
  int error_cnt = 0, samples_checked = 0, cyc = 0;
  vpos_aux #(.TICK_CYCLES(10)) DUT (.REF_CLK(REF_CLK), .RST_N(RST_N), .PSEL(PSEL),
    .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
    .PREADY(PREADY), .PSLVERR(PSLVERR), .SETPOINT_MA(SETPOINT_MA), .POSITION(POSITION),
    .BIN_IN(BIN_IN), .MODE_SW(MODE_SW), .TUNE_DONE(TUNE_DONE), .TUNE_RES(TUNE_RES),
    .TUNE_ACTIVE(TUNE_ACTIVE), .DRIVE(DRIVE), .SP_ERR_LED(SP_ERR_LED), .ANALOG_OUT(ANALOG_OUT));
  vpos_far far (.clk(REF_CLK), .rst_n(RST_N), .hold_pos(hold), .drive(DRIVE),
    .tune_active(TUNE_ACTIVE), .position(POSITION), .tune_done(TUNE_DONE), .tune_res(TUNE_RES));
  initial forever #4 REF_CLK = ~REF_CLK;
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] x, input logic [31:0] g);
    samples_checked++;
    if (g !== x) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", n, x, g);
    end
  endtask
  task automatic chkb(input string n, input logic x, input logic g);
    chk(n, {31'h0, x}, {31'h0, g});
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge REF_CLK);
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge REF_CLK);
    PSEL <= 1; PENABLE <= 0; PWRITE <= w; PADDR <= a; PWDATA <= d;
    @(posedge REF_CLK);
    PENABLE <= 1;
    do @(posedge REF_CLK); while (PREADY !== 1'b1);
    r = PRDATA;
    e = PSLVERR;
    PSEL <= 0;
    PENABLE <= 0;
  endtask
  task automatic rdc(input string n, input logic [7:0] a, input logic [31:0] x);
    apb(0, a, 0);
    chk(n, x, r);
  endtask
  task automatic t_regs;
    rdc("ctrl", OFS_CTRL, 32'h0);
    rdc("limit", OFS_LIMIT, {6'h0, HI_RESET, 6'h0, LO_RESET});
    rdc("time", OFS_TIME, {18'h0, T_RESET, 2'h0, T_RESET});
    rdc("loop", OFS_LOOP, {KP_RESET, KP_RESET, 6'h0, DB_RESET});
    rdc("safe", OFS_SAFE, 32'h0);
    apb(1, OFS_LIMIT, {6'h0, 10'h2BC, 6'h0, 10'h258});
    rdc("limit push", OFS_LIMIT, {6'h0, FULL, 6'h0, HALF});
    apb(1, OFS_LIMIT, {6'h0, 10'h258, 6'h0, HALF});
    rdc("limit pull", OFS_LIMIT, {6'h0, 10'h258, 6'h0, 10'h064});
    apb(1, OFS_TIME, {18'h0, 6'h3F, 2'h0, 6'h00});
    rdc("time clamp", OFS_TIME, {18'h0, T_MAX, 2'h0, T_MIN});
    apb(0, 8'h18, 0);
    chk("unmapped data", 32'h0, r);
    chkb("unmapped err", 1, e);
    apb(1, OFS_STATUS, 32'hFFFFFFFF);
    chkb("status err", 1, e);
    $display("test regs done");
  endtask
  task automatic t_scale;
    MODE_SW <= 1;
    apb(1, OFS_LIMIT, {6'h0, HALF, 6'h0, 10'h000});
    hold <= 10'h258;
    tick(10);
    apb(0, OFS_STATUS, 0);
    chk("scale over", 32'h4B0, {20'h0, r[11:0]});
    chkb("manual", 1, r[ST_MANUAL]);
    apb(1, OFS_LIMIT, {6'h0, FULL, 6'h0, HALF});
    hold <= 10'h0FA;
    tick(10);
    apb(0, OFS_STATUS, 0);
    chk("scale under", 32'hE0C, {20'h0, r[11:0]});
    MODE_SW <= 0;
    $display("test scale done");
  endtask
  task automatic t_fault;
    apb(1, OFS_CTRL, 32'h08);
    SETPOINT_MA <= MA_FAULT;
    tick(4);
    chkb("led set", 1, SP_ERR_LED);
    SETPOINT_MA <= 12'h168;
    tick(4);
    chkb("led hyst", 1, SP_ERR_LED);
    SETPOINT_MA <= 12'h169;
    tick(4);
    chkb("led clear", 0, SP_ERR_LED);
    apb(1, OFS_CTRL, 32'h18);
    rdc("ctrl 0-20", OFS_CTRL, 32'h10);
    SETPOINT_MA <= 12'h12C;
    tick(4);
    chkb("led 0-20", 0, SP_ERR_LED);
    SETPOINT_MA <= 12'h4B0;
    $display("test fault done");
  endtask
  task automatic t_tune;
    apb(1, OFS_CTRL, 32'h80);
    tick(1);
    chkb("tune run", 1, TUNE_ACTIVE);
    for (int i = 0; i < 100 && TUNE_ACTIVE === 1'b1; i++) tick(1);
    rdc("tuned time", OFS_TIME, {18'h0, 6'h07, 2'h0, 6'h05});
    rdc("tuned band", OFS_LOOP, {KP_RESET, KP_RESET, 6'h0, 10'h014});
    apb(1, OFS_LOOP, {8'h20, 8'h10, 6'h0, 10'h01E});
    rdc("band edit", OFS_LOOP, {8'h20, 8'h10, 6'h0, 10'h01E});
    MODE_SW <= 1;
    apb(1, OFS_CTRL, 32'h80);
    tick(2);
    chkb("tune manual", 0, TUNE_ACTIVE);
    MODE_SW <= 0;
    apb(1, OFS_CTRL, 32'h03);
    BIN_IN <= 1;
    tick(3);
    chkb("tune bin", 1, TUNE_ACTIVE);
    for (int i = 0; i < 100 && TUNE_ACTIVE === 1'b1; i++) tick(1);
    BIN_IN <= 0;
    $display("test tune done");
  endtask
  task automatic t_bin;
    apb(1, OFS_CTRL, 32'h02);
    MODE_SW <= 1;
    tick(3);
    apb(0, OFS_STATUS, 0);
    chkb("bin auto", 0, r[ST_MANUAL]);
    BIN_IN <= 1;
    tick(3);
    apb(0, OFS_STATUS, 0);
    chkb("bin manual", 1, r[ST_MANUAL]);
    BIN_IN <= 0;
    apb(1, OFS_CTRL, 32'h05);
    MODE_SW <= 0;
    BIN_IN <= 1;
    tick(3);
    apb(0, OFS_STATUS, 0);
    chkb("safe auto", 1, r[ST_SAFE]);
    MODE_SW <= 1;
    tick(3);
    apb(0, OFS_STATUS, 0);
    chkb("safe manual", 0, r[ST_SAFE]);
    BIN_IN <= 0;
    MODE_SW <= 0;
    $display("test bin done");
  endtask
  task automatic t_out;
    apb(1, OFS_CTRL, 32'h20);
    // Set-point output is taken unramped from sp_pct; no ramp to wait for
    tick(6000);
    chk("out 4-20", 32'h4B0, {20'h0, ANALOG_OUT});
    apb(1, OFS_CTRL, 32'h60);
    tick(4);
    chk("out 0-20", 32'h3E8, {20'h0, ANALOG_OUT});
    $display("test out done");
  endtask
  initial begin
    tick(6);
    RST_N <= 1;
    t_regs();
    t_scale();
    t_fault();
    t_tune();
    t_bin();
    t_out();
    end_of_test();
  end
  initial forever begin
    @(posedge REF_CLK);
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      end_of_test();
    end
  end
endmodule
`default_nettype wire
